// ===== pkg/tcg_defines.svh
// Register offsets, field positions, reset values and fixed figures of the glyph configuration
`ifndef TCG_DEFINES_SVH
`define TCG_DEFINES_SVH

// ==========================================================
// Register offsets
`define TCG_OFS_MEM_CFG      8'h00
`define TCG_OFS_CHAR_WIDTH   8'h01
`define TCG_OFS_CG_START_LO  8'h19
`define TCG_OFS_CG_START_HI  8'h1a
`define TCG_OFS_STATUS       8'h30

// ==========================================================
// Field positions
`define TCG_BIT_SRC          0
`define TCG_BIT_RSVD1        1
`define TCG_BIT_HEIGHT       2
`define TCG_BIT_ORIGIN       5
`define TCG_BIT_AC_SEL       7

// ==========================================================
// Reset values and write mask
`define TCG_RST_MEM_CFG      8'h10
`define TCG_RST_CHAR_WIDTH   8'h87
`define TCG_MEM_CFG_WMASK    8'hfd

// ==========================================================
// Fixed figures
`define TCG_ROM_GLYPHS       9'h0a0
`define TCG_ROM_GLYPH_W      4'h5
`define TCG_ROM_GLYPH_H      5'h07
`define TCG_RAM_GLYPHS_MAX   9'h100
`define TCG_RAM_GLYPHS_ROM   9'h040
`define TCG_HEIGHT_SMALL     5'h08
`define TCG_HEIGHT_LARGE     5'h10
`define TCG_SEG_PIXELS       4'h8
`define TCG_AC_LINES         5'h10
`define TCG_AC_FRAMES        2'h2
`define TCG_GLYPH_BYTES_8    16'h0008
`define TCG_GLYPH_BYTES_16   16'h0010

`endif

// ===== pkg/tcg_pkg.sv
// Types shared by the glyph configuration modules
package tcg_pkg;

   typedef enum logic {
      TCG_SRC_ROM,
      TCG_SRC_RAM
   } tcg_src_t;

   typedef enum logic {
      TCG_AC_LINE16,
      TCG_AC_FRAME2
   } tcg_ac_t;

endpackage

// ===== pkg/tcg_pix_if.sv
// Pixel mask path between the configuration core and the segment masking module
`timescale 1ns/10ps
interface tcg_pix_if;
   logic [3:0] width_m1;
   logic [3:0] col;
   logic       origin_on;
   logic [4:0] row;
   logic [4:0] height;
   logic       last_block_row;
   logic       show;

   modport core (
      output width_m1,
      output col,
      output origin_on,
      output row,
      output height,
      output last_block_row,
      input  show
   );

   modport mask (
      input  width_m1,
      input  col,
      input  origin_on,
      input  row,
      input  height,
      input  last_block_row,
      output show
   );
endinterface

// ===== hdl/tcg_pix_mask.sv
// Decides whether one glyph pixel is visible for width and origin shift
`timescale 1ns/10ps
`include "tcg_defines.svh"
module tcg_pix_mask (
   tcg_pix_if.mask pix
);
   logic [4:0] shifted_row;
   logic       in_width;
   logic       lost_row;

   always_comb begin
      // Cell width is field plus one; columns past it in the last segment stay dark
      in_width    = (pix.col <= pix.width_m1);
      // Font drawn one row lower; its bottom row on the block's last line is dropped
      shifted_row = pix.origin_on ? pix.row + 5'h01 : pix.row;
      lost_row    = pix.origin_on && pix.last_block_row
                    && (pix.row == pix.height - 5'h01);
      pix.show    = in_width && !lost_row && (shifted_row <= pix.height);
   end
endmodule

// ===== hdl/tcg_char_gen_cfg.sv
// Character generator and AC drive configuration registers with fetch-side decode
`timescale 1ns/10ps
`include "tcg_defines.svh"
// Function
// - Height bit gives 8-pixel glyphs when clear, 16 when set
// - Memory configuration bit 1 is reserved and reads zero
// - Source bit picks fixed glyph ROM when clear, user glyph RAM when set
// - Fixed ROM holds 160 glyphs of 5 by 7 pixels
// - User RAM as source holds up to 256 glyphs
// - User glyphs located from the start address register pair
// - With ROM selected, user RAM limited to 64 glyphs of 8 by 8
// - User glyph RAM use allows only one bit per pixel
// - AC select inverts every 16 lines when clear, every two frames when set
// - Four-bit width field in character size bits 3 to 0
// - Data fetched in 8-bit segments; characters wider than eight pixels use two segments
// - Pixels beyond width in the last segment are hidden
// - Default character field width is eight pixels
// - Origin compensation shifts font down one row
// - With compensation, bottom glyph row on block's last line is hidden
// - Bit 5 clear enables origin compensation, set disables it
// - Any memory configuration write resets timing and blanks display
module tcg_char_gen_cfg (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_srst,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // Display timing
   input  wire logic        i_line_strobe,
   input  wire logic        i_frame_strobe,
   input  wire logic        i_bpp_one,
   output logic             o_timing_reset,
   output logic             o_display_off,
   output logic             o_ac_drive,
   // Glyph fetch
   input  wire logic [7:0]  i_glyph_code,
   input  wire logic [4:0]  i_glyph_row,
   input  wire logic [3:0]  i_pixel_col,
   input  wire logic        i_last_block_row,
   input  wire logic        i_display_on,
   output logic             o_use_ram,
   output logic             o_code_valid,
   output logic      [15:0] o_glyph_addr,
   output logic      [4:0]  o_char_height,
   output logic      [1:0]  o_segments,
   output logic             o_pixel_show,
   output logic             o_bpp_error
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0]  mem_cfg;
      logic [7:0]  width_ac;
      logic [15:0] cg_start;
      logic [7:0]  rdata;
      logic        timing_reset;
      logic        display_off;
      logic        ac_drive;
      logic [4:0]  line_cnt;
      logic [1:0]  frame_cnt;
      logic        use_ram;
      logic        code_valid;
      logic [15:0] glyph_addr;
      logic [4:0]  char_height;
      logic [1:0]  segments;
      logic        pixel_show;
      logic        bpp_error;
   } tcg_state_t;

   tcg_state_t st_reg;
   tcg_state_t st_next;

   tcg_pix_if        pix ();
   tcg_pkg::tcg_src_t src;
   tcg_pkg::tcg_ac_t  ac_mode;
   logic [4:0]       height;
   logic [15:0]      glyph_bytes;

   tcg_pix_mask u_mask (
      .pix (pix)
   );

   assign src     = tcg_pkg::tcg_src_t'(st_reg.mem_cfg[`TCG_BIT_SRC]);
   assign ac_mode = tcg_pkg::tcg_ac_t'(st_reg.width_ac[`TCG_BIT_AC_SEL]);
   assign height  = st_reg.mem_cfg[`TCG_BIT_HEIGHT] ? `TCG_HEIGHT_LARGE
                                                     : `TCG_HEIGHT_SMALL;
   assign glyph_bytes = st_reg.mem_cfg[`TCG_BIT_HEIGHT] ? `TCG_GLYPH_BYTES_16
                                                         : `TCG_GLYPH_BYTES_8;

   assign pix.width_m1       = st_reg.width_ac[3:0];
   assign pix.col            = i_pixel_col;
   assign pix.origin_on      = !st_reg.mem_cfg[`TCG_BIT_ORIGIN];
   assign pix.row            = i_glyph_row;
   // Fixed glyphs have seven rows but sit in the same selected cell height
   assign pix.height         = height;
   assign pix.last_block_row = i_last_block_row;

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.timing_reset = 1'b0;
      st_next.rdata = 8'h00;
      if (i_wr) begin
         case (i_addr)
            `TCG_OFS_MEM_CFG: begin
               // Reserved bit 1 is never stored
               st_next.mem_cfg      = i_wdata & `TCG_MEM_CFG_WMASK;
               st_next.timing_reset = 1'b1;
               st_next.display_off  = 1'b1;
               st_next.line_cnt     = 5'h00;
               st_next.frame_cnt    = 2'h0;
            end
            `TCG_OFS_CHAR_WIDTH:  st_next.width_ac       = i_wdata & 8'h8f;
            `TCG_OFS_CG_START_LO: st_next.cg_start[7:0]  = i_wdata;
            `TCG_OFS_CG_START_HI: st_next.cg_start[15:8] = i_wdata;
            default: ;
         endcase
      end
      if (i_display_on && !(i_wr && i_addr == `TCG_OFS_MEM_CFG)) begin
         st_next.display_off = 1'b0;
      end
      if (i_rd) begin
         case (i_addr)
            `TCG_OFS_MEM_CFG:     st_next.rdata = st_reg.mem_cfg;
            `TCG_OFS_CHAR_WIDTH:  st_next.rdata = st_reg.width_ac;
            `TCG_OFS_CG_START_LO: st_next.rdata = st_reg.cg_start[7:0];
            `TCG_OFS_CG_START_HI: st_next.rdata = st_reg.cg_start[15:8];
            `TCG_OFS_STATUS:      st_next.rdata = {5'h00, st_reg.bpp_error,
                                                   st_reg.display_off, st_reg.ac_drive};
            default:              st_next.rdata = 8'h00;
         endcase
      end

      // AC drive polarity toggles on its selected period
      if (!(i_wr && i_addr == `TCG_OFS_MEM_CFG)) begin
         case (ac_mode)
            tcg_pkg::TCG_AC_LINE16: begin
               if (i_line_strobe) begin
                  if (st_reg.line_cnt == `TCG_AC_LINES - 5'h01) begin
                     st_next.line_cnt = 5'h00;
                     st_next.ac_drive = !st_reg.ac_drive;
                  end else begin
                     st_next.line_cnt = st_reg.line_cnt + 5'h01;
                  end
               end
            end
            tcg_pkg::TCG_AC_FRAME2: begin
               if (i_frame_strobe) begin
                  if (st_reg.frame_cnt == `TCG_AC_FRAMES - 2'h1) begin
                     st_next.frame_cnt = 2'h0;
                     st_next.ac_drive  = !st_reg.ac_drive;
                  end else begin
                     st_next.frame_cnt = st_reg.frame_cnt + 2'h1;
                  end
               end
            end
            default: ;
         endcase
      end

      // Glyph source decode
      st_next.use_ram = (src == tcg_pkg::TCG_SRC_RAM);
      if (src == tcg_pkg::TCG_SRC_RAM) begin
         st_next.code_valid = ({1'b0, i_glyph_code} < `TCG_RAM_GLYPHS_MAX);
         st_next.glyph_addr = st_reg.cg_start
                              + 16'(i_glyph_code) * glyph_bytes;
      end else begin
         // ROM codes below 160; codes above map to the small user area of 64
         if ({1'b0, i_glyph_code} < `TCG_ROM_GLYPHS) begin
            st_next.code_valid = 1'b1;
            st_next.glyph_addr = 16'(i_glyph_code) * 16'(`TCG_ROM_GLYPH_H);
         end else begin
            st_next.code_valid = ({1'b0, i_glyph_code} - `TCG_ROM_GLYPHS)
                                 < `TCG_RAM_GLYPHS_ROM;
            st_next.glyph_addr = st_reg.cg_start
                                 + 16'(i_glyph_code - 8'ha0) * `TCG_GLYPH_BYTES_8;
         end
      end
      st_next.char_height = pix.height;
      // Width of field plus one, grouped into 8-pixel fetches
      st_next.segments   = st_reg.width_ac[3] ? 2'h2 : 2'h1;
      st_next.pixel_show = pix.show;
      // User glyphs only in one bit per pixel
      st_next.bpp_error  = (st_next.use_ram || ({1'b0, i_glyph_code} >= `TCG_ROM_GLYPHS))
                           && !i_bpp_one;
      if (i_srst) begin
         st_next = '0;
         st_next.mem_cfg  = `TCG_RST_MEM_CFG;
         st_next.width_ac = `TCG_RST_CHAR_WIDTH;
      end
   end

   always_ff @(posedge i_core_clk) begin
      st_reg <= st_next;
   end

   assign o_rdata        = st_reg.rdata;
   assign o_timing_reset = st_reg.timing_reset;
   assign o_display_off  = st_reg.display_off;
   assign o_ac_drive     = st_reg.ac_drive;
   assign o_use_ram      = st_reg.use_ram;
   assign o_code_valid   = st_reg.code_valid;
   assign o_glyph_addr   = st_reg.glyph_addr;
   assign o_char_height  = st_reg.char_height;
   assign o_segments     = st_reg.segments;
   assign o_pixel_show   = st_reg.pixel_show;
   assign o_bpp_error    = st_reg.bpp_error;

   // ==========================================================
   // Checks
   a_rsvd_bit_zero : assert property (@(posedge i_core_clk) disable iff (i_srst)
      !st_reg.mem_cfg[`TCG_BIT_RSVD1]) else $error("reserved bit set");
   a_cfg_write_reset : assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_wr && i_addr == `TCG_OFS_MEM_CFG |=> o_timing_reset && o_display_off)
      else $error("config write did not reset timing");
   a_height_select : assert property (@(posedge i_core_clk) disable iff (i_srst)
      st_reg.mem_cfg[`TCG_BIT_SRC] && !$past(i_srst) |=> o_char_height ==
      ($past(st_reg.mem_cfg[`TCG_BIT_HEIGHT]) ? 5'h10 : 5'h08))
      else $error("wrong glyph height");
   a_source_select : assert property (@(posedge i_core_clk) disable iff (i_srst)
      1'b1 |=> o_use_ram == $past(st_reg.mem_cfg[`TCG_BIT_SRC]))
      else $error("wrong glyph source");
   a_ac_frames : assert property (@(posedge i_core_clk) disable iff (i_srst)
      ac_mode == tcg_pkg::TCG_AC_FRAME2 && !i_frame_strobe && !i_wr |=> $stable(o_ac_drive))
      else $error("AC drive toggled without frame");
   a_rom_limit : assert property (@(posedge i_core_clk) disable iff (i_srst)
      !st_reg.mem_cfg[`TCG_BIT_SRC] && i_glyph_code >= 8'he0 |=> !o_code_valid)
      else $error("code past user area accepted");
   a_bpp_check : assert property (@(posedge i_core_clk) disable iff (i_srst)
      st_reg.mem_cfg[`TCG_BIT_SRC] && !i_bpp_one |=> o_bpp_error)
      else $error("deep format with user glyphs not flagged");
   a_width_hide : assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_pixel_col > st_reg.width_ac[3:0] |=> !o_pixel_show)
      else $error("pixel beyond width shown");
   a_origin_drop : assert property (@(posedge i_core_clk) disable iff (i_srst)
      pix.origin_on && i_last_block_row && i_glyph_row == pix.height - 5'h01
      |=> !o_pixel_show) else $error("lost row shown");
   a_width_show : assert property (@(posedge i_core_clk) disable iff (i_srst)
      !pix.origin_on && i_pixel_col <= st_reg.width_ac[3:0] && i_glyph_row < pix.height
      |=> o_pixel_show) else $error("pixel inside width hidden");
   a_ac_lines : assert property (@(posedge i_core_clk) disable iff (i_srst)
      ac_mode == tcg_pkg::TCG_AC_LINE16 && !i_line_strobe |=> $stable(o_ac_drive))
      else $error("AC drive toggled without line");
   a_ac_line_flip : assert property (@(posedge i_core_clk) disable iff (i_srst)
      ac_mode == tcg_pkg::TCG_AC_LINE16 && i_line_strobe && st_reg.line_cnt == 5'h0f
      && !(i_wr && i_addr == `TCG_OFS_MEM_CFG) |=> o_ac_drive != $past(o_ac_drive))
      else $error("AC drive missed sixteenth line");
   a_ac_frame_flip : assert property (@(posedge i_core_clk) disable iff (i_srst)
      ac_mode == tcg_pkg::TCG_AC_FRAME2 && i_frame_strobe && st_reg.frame_cnt == 2'h1
      && !(i_wr && i_addr == `TCG_OFS_MEM_CFG) |=> o_ac_drive != $past(o_ac_drive))
      else $error("AC drive missed second frame");
   a_rom_codes : assert property (@(posedge i_core_clk) disable iff (i_srst)
      !st_reg.mem_cfg[`TCG_BIT_SRC] && i_glyph_code < 8'ha0 |=> o_code_valid)
      else $error("fixed glyph code refused");
   a_rom_addr : assert property (@(posedge i_core_clk) disable iff (i_srst)
      !st_reg.mem_cfg[`TCG_BIT_SRC] && i_glyph_code < 8'ha0
      |=> o_glyph_addr == {8'h00, $past(i_glyph_code)} * 16'h0007)
      else $error("wrong fixed glyph address");
   a_ram_codes : assert property (@(posedge i_core_clk) disable iff (i_srst)
      st_reg.mem_cfg[`TCG_BIT_SRC] |=> o_code_valid)
      else $error("user glyph code refused");
   a_ram_addr : assert property (@(posedge i_core_clk) disable iff (i_srst)
      st_reg.mem_cfg[`TCG_BIT_SRC] && !st_reg.mem_cfg[`TCG_BIT_HEIGHT]
      |=> o_glyph_addr == $past(st_reg.cg_start) + {5'h00, $past(i_glyph_code), 3'h0})
      else $error("wrong user glyph address");
   a_user_area : assert property (@(posedge i_core_clk) disable iff (i_srst)
      !st_reg.mem_cfg[`TCG_BIT_SRC] && i_glyph_code >= 8'ha0 && i_glyph_code < 8'he0
      |=> o_code_valid) else $error("user area code refused");
   a_two_segments : assert property (@(posedge i_core_clk) disable iff (i_srst)
      st_reg.width_ac[3:0] > 4'h7 |=> o_segments == 2'h2)
      else $error("wide cell not split in two fetches");
   a_one_segment : assert property (@(posedge i_core_clk) disable iff (i_srst)
      st_reg.width_ac[3:0] <= 4'h7 |=> o_segments == 2'h1)
      else $error("narrow cell fetched twice");
   a_width_default : assert property (@(posedge i_core_clk) disable iff (i_srst)
      $past(i_srst) |-> st_reg.width_ac[3:0] == 4'h7)
      else $error("default cell width not eight");
   a_reset_config : assert property (@(posedge i_core_clk) disable iff (i_srst)
      $past(i_srst) |-> st_reg.mem_cfg == `TCG_RST_MEM_CFG)
      else $error("wrong configuration after reset");
   a_origin_shift : assert property (@(posedge i_core_clk) disable iff (i_srst)
      pix.origin_on && !i_last_block_row && i_glyph_row == pix.height - 5'h01
      && i_pixel_col <= st_reg.width_ac[3:0] |=> o_pixel_show)
      else $error("shifted bottom row lost inside block");
   a_origin_off : assert property (@(posedge i_core_clk) disable iff (i_srst)
      st_reg.mem_cfg[`TCG_BIT_ORIGIN] && i_glyph_row == pix.height - 5'h01
      && i_pixel_col <= st_reg.width_ac[3:0] |=> o_pixel_show)
      else $error("bottom row lost without compensation");
   a_timing_pulse : assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_timing_reset && !(i_wr && i_addr == `TCG_OFS_MEM_CFG) |=> !o_timing_reset)
      else $error("timing reset held too long");
   a_rsvd_read : assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_rd && i_addr == `TCG_OFS_MEM_CFG |=> !o_rdata[`TCG_BIT_RSVD1])
      else $error("reserved bit read as one");
   a_width_field : assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_wr && i_addr == `TCG_OFS_CHAR_WIDTH |=> st_reg.width_ac[3:0] == $past(i_wdata[3:0]))
      else $error("width field not stored");
   a_start_low : assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_wr && i_addr == `TCG_OFS_CG_START_LO |=> st_reg.cg_start[7:0] == $past(i_wdata))
      else $error("start address low byte not stored");
   a_start_high : assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_wr && i_addr == `TCG_OFS_CG_START_HI |=> st_reg.cg_start[15:8] == $past(i_wdata))
      else $error("start address high byte not stored");
endmodule

// ===== testbench/tcg_char_gen_cfg_bench.sv
// Self-checking bench for the glyph configuration block
`timescale 1ns/10ps
`include "tcg_defines.svh"
module tcg_char_gen_cfg_bench;
   logic        i_core_clk;
   logic        i_srst;
   logic [7:0]  i_addr;
   logic [7:0]  i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [7:0]  o_rdata;
   logic        i_line_strobe;
   logic        i_frame_strobe;
   logic        i_bpp_one;
   logic        o_timing_reset;
   logic        o_display_off;
   logic        o_ac_drive;
   logic [7:0]  i_glyph_code;
   logic [4:0]  i_glyph_row;
   logic [3:0]  i_pixel_col;
   logic        i_last_block_row;
   logic        i_display_on;
   logic        o_use_ram;
   logic        o_code_valid;
   logic [15:0] o_glyph_addr;
   logic [4:0]  o_char_height;
   logic [1:0]  o_segments;
   logic        o_pixel_show;
   logic        o_bpp_error;
   int          fail_count;
   int          cmp_count;
   int          cycles;
   logic [7:0]  rdv;

   tcg_char_gen_cfg u_tcg_char_gen_cfg (
      .i_core_clk       (i_core_clk),
      .i_srst           (i_srst),
      .i_addr           (i_addr),
      .i_wdata          (i_wdata),
      .i_wr             (i_wr),
      .i_rd             (i_rd),
      .o_rdata          (o_rdata),
      .i_line_strobe    (i_line_strobe),
      .i_frame_strobe   (i_frame_strobe),
      .i_bpp_one        (i_bpp_one),
      .o_timing_reset   (o_timing_reset),
      .o_display_off    (o_display_off),
      .o_ac_drive       (o_ac_drive),
      .i_glyph_code     (i_glyph_code),
      .i_glyph_row      (i_glyph_row),
      .i_pixel_col      (i_pixel_col),
      .i_last_block_row (i_last_block_row),
      .i_display_on     (i_display_on),
      .o_use_ram        (o_use_ram),
      .o_code_valid     (o_code_valid),
      .o_glyph_addr     (o_glyph_addr),
      .o_char_height    (o_char_height),
      .o_segments       (o_segments),
      .o_pixel_show     (o_pixel_show),
      .o_bpp_error      (o_bpp_error)
   );

   // ==========================================================
   // Clock, timeout and verdict
   initial i_core_clk = 1'b0;
   always #5 i_core_clk = ~i_core_clk;

   // Whole sequence needs well under a thousand cycles
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count = fail_count + 1;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // ==========================================================
   // Register port and stimulus tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   // Fetch outputs are registered one cycle after the inputs
   task automatic gl(input logic [7:0] c, input logic [4:0] r, input logic [3:0] col,
                     input logic last);
      @(posedge i_core_clk);
      i_glyph_code     <= c;
      i_glyph_row      <= r;
      i_pixel_col      <= col;
      i_last_block_row <= last;
      repeat (2) @(posedge i_core_clk);
      #1;
   endtask

   task automatic pl(input logic frame, input int n);
      repeat (n) begin
         @(posedge i_core_clk);
         if (frame)
            i_frame_strobe <= 1'b1;
         else
            i_line_strobe <= 1'b1;
         @(posedge i_core_clk);
         i_frame_strobe <= 1'b0;
         i_line_strobe  <= 1'b0;
      end
      repeat (2) @(posedge i_core_clk);
      #1;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      {i_addr, i_wdata, i_wr, i_rd, i_line_strobe, i_frame_strobe} = '0;
      {i_glyph_code, i_glyph_row, i_pixel_col, i_last_block_row, i_display_on} = '0;
      i_srst = 1'b1;
      i_bpp_one = 1'b1;
      fail_count = 0;
      cmp_count = 0;
      repeat (6) @(posedge i_core_clk);
      i_srst <= 1'b0;
      rd(8'h00, rdv);
      chk(rdv, 8'h10);
      rd(8'h01, rdv);
      chk(rdv, 8'h87);
      rd(8'h55, rdv);
      chk(rdv, 8'h00);
      gl(8'h0a, 5'h00, 4'h7, 1'b0);
      chk(o_segments, 2'h1);
      chk(o_pixel_show, 1'b1);
      // Configuration write restarts timing and blanks the panel
      wr(8'h00, 8'hff);
      #1;
      chk(o_timing_reset, 1'b1);
      chk(o_display_off, 1'b1);
      @(posedge i_core_clk);
      #1;
      chk(o_timing_reset, 1'b0);
      rd(8'h00, rdv);
      chk(rdv, 8'hfd);
      rd(8'h30, rdv);
      chk(rdv[1], 1'b1);
      @(posedge i_core_clk);
      i_display_on <= 1'b1;
      @(posedge i_core_clk);
      i_display_on <= 1'b0;
      @(posedge i_core_clk);
      #1;
      chk(o_display_off, 1'b0);
      // User glyph RAM addressing from the start address pair
      wr(8'h00, 8'h31);
      wr(8'h19, 8'h34);
      wr(8'h1a, 8'h12);
      gl(8'h03, 5'h00, 4'h0, 1'b0);
      chk(o_use_ram, 1'b1);
      chk(o_char_height, 5'h08);
      chk(o_glyph_addr, 16'h124c);
      chk(o_bpp_error, 1'b0);
      wr(8'h00, 8'h35);
      gl(8'hff, 5'h00, 4'h0, 1'b0);
      chk(o_char_height, 5'h10);
      chk(o_code_valid, 1'b1);
      chk(o_glyph_addr, 16'h2224);
      @(posedge i_core_clk);
      i_bpp_one <= 1'b0;
      gl(8'hff, 5'h00, 4'h0, 1'b0);
      chk(o_bpp_error, 1'b1);
      rd(8'h30, rdv);
      chk(rdv[2], 1'b1);
      @(posedge i_core_clk);
      i_bpp_one <= 1'b1;
      // Fixed ROM with the small user area above it
      wr(8'h00, 8'h30);
      gl(8'h0a, 5'h07, 4'h0, 1'b1);
      chk(o_use_ram, 1'b0);
      chk(o_code_valid, 1'b1);
      chk(o_glyph_addr, 16'h0046);
      chk(o_pixel_show, 1'b1);
      gl(8'hc8, 5'h00, 4'h0, 1'b0);
      chk(o_code_valid, 1'b1);
      chk(o_glyph_addr, 16'h1374);
      gl(8'he6, 5'h00, 4'h0, 1'b0);
      chk(o_code_valid, 1'b0);
      // Origin compensation drops the bottom row at the block edge
      wr(8'h00, 8'h10);
      gl(8'h0a, 5'h07, 4'h0, 1'b1);
      chk(o_pixel_show, 1'b0);
      gl(8'h0a, 5'h06, 4'h0, 1'b1);
      chk(o_pixel_show, 1'b1);
      gl(8'h0a, 5'h07, 4'h0, 1'b0);
      chk(o_pixel_show, 1'b1);
      // Twelve pixel cell spans two segments, rest of second hidden
      wr(8'h01, 8'h8b);
      gl(8'h0a, 5'h00, 4'hb, 1'b0);
      chk(o_segments, 2'h2);
      chk(o_pixel_show, 1'b1);
      gl(8'h0a, 5'h00, 4'hc, 1'b0);
      chk(o_pixel_show, 1'b0);
      wr(8'h01, 8'hff);
      rd(8'h01, rdv);
      chk(rdv, 8'h8f);
      // AC polarity: sixteen lines, then two frames
      wr(8'h01, 8'h07);
      wr(8'h00, 8'h10);
      repeat (2) @(posedge i_core_clk);
      #1;
      chk(o_ac_drive, 1'b0);
      pl(1'b0, 15);
      chk(o_ac_drive, 1'b0);
      pl(1'b0, 1);
      chk(o_ac_drive, 1'b1);
      wr(8'h01, 8'h87);
      wr(8'h00, 8'h10);
      repeat (2) @(posedge i_core_clk);
      #1;
      chk(o_ac_drive, 1'b1);
      pl(1'b0, 20);
      chk(o_ac_drive, 1'b1);
      pl(1'b1, 1);
      chk(o_ac_drive, 1'b1);
      pl(1'b1, 1);
      chk(o_ac_drive, 1'b0);
      conclude();
   end
endmodule
